// ---- logic/alarm_channel.v ----
// one audible alarm with its operator silence latch
`timescale 1ns/1ps
module alarm_channel (
  input wire core_clk,
  input wire rst_n,
  input wire ctrl_bit,
  input wire silence_btn,
  output wire alarm_on
);
  reg sync1_r;
  reg sync2_r;
  reg silenced_r;
  wire silenced_nxt;

  // pushbutton is a console pin, so two flops before any use
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= silence_btn;
      sync2_r <= sync1_r;
    end
  end

  // latch cleared while the bit is zero, so only a fresh set re-arms
  assign silenced_nxt = ctrl_bit & (silenced_r | sync2_r);

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      silenced_r <= 1'b0;
    end else begin
      silenced_r <= silenced_nxt;
    end
  end

  // sounds whenever the bit is set and not silenced
  assign alarm_on = ctrl_bit & ~silenced_r;
endmodule // alarm_channel

// ---- logic/warning_light_defines.vh ----
// constants for the warning light register block
`ifndef WARNING_LIGHT_DEFINES_VH
`define WARNING_LIGHT_DEFINES_VH
`define WL_REG_COUNT 8
`define WL_WORD_W 32
`define WL_IDX_W 3
`define WL_BITS 256
`define WL_REG_RESET 32'h00000000
`define WL_LAST_IDX 3'h7
`define WL_ALARM_COUNT 8
`endif

// ---- logic/warning_light_driver.v ----
// warning light storage registers with lamp and alarm outputs
`timescale 1ns/1ps
`include "warning_light_defines.vh"
module warning_light_driver (
  input wire core_clk,
  input wire rst_n,
  input wire xfer_start,
  input wire word_strobe,
  input wire [`WL_WORD_W-1:0] word_data,
  input wire [`WL_ALARM_COUNT-1:0] silence_btn,
  output wire xfer_busy,
  output reg xfer_done,
  output wire [`WL_BITS-1:0] lamp_out,
  output wire [`WL_ALARM_COUNT-1:0] alarm_out
);
  localparam ST_IDLE = 1'b0;
  localparam ST_LOAD = 1'b1;

  reg state_r;
  reg state_nxt;
  reg [`WL_IDX_W-1:0] idx_r;
  reg [`WL_IDX_W-1:0] idx_nxt;
  reg [`WL_WORD_W-1:0] store_r [0:`WL_REG_COUNT-1];
  wire load_en;
  integer i;

  // a word is accepted only inside a transfer; stray strobes are ignored
  assign load_en = (state_r == ST_LOAD) & word_strobe;
  assign xfer_busy = (state_r == ST_LOAD);

  // transfer control: start opens a frame, eighth word closes it
  always @* begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    case (state_r)
      ST_IDLE: begin
        idx_nxt = 3'h0;
        if (xfer_start) begin
          state_nxt = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (word_strobe) begin
          idx_nxt = idx_r + 3'h1;
          if (idx_r == `WL_LAST_IDX) begin
            state_nxt = ST_IDLE;
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        idx_nxt = 3'h0;
      end
    endcase
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      idx_r <= 3'h0;
      xfer_done <= 1'b0;
    end else begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      xfer_done <= load_en & (idx_r == `WL_LAST_IDX);
    end
  end

  // whole-word overwrite; a zero bit clears its light, no read-modify-write
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < `WL_REG_COUNT; i = i + 1) begin
        store_r[i] <= `WL_REG_RESET;
      end
    end else if (load_en) begin
      store_r[idx_r] <= word_data;
    end
  end

  // fixed patch: indicator n follows flat storage bit n
  genvar g;
  generate
    for (g = 0; g < `WL_REG_COUNT; g = g + 1) begin : g_lamp
      assign lamp_out[g*`WL_WORD_W +: `WL_WORD_W] = store_r[g];
    end
    // alarm k is patched to bit 0 of register k
    for (g = 0; g < `WL_ALARM_COUNT; g = g + 1) begin : g_alarm
      alarm_channel u_alarm (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .ctrl_bit(store_r[g][0]),
        .silence_btn(silence_btn[g]),
        .alarm_on(alarm_out[g])
      );
    end
  endgenerate
endmodule // warning_light_driver

// ---- sim/host_image.sv ----
// computer side: sends its whole image as one transfer
`timescale 1ns/1ps
module host_image (
  input wire core_clk,
  input wire go,
  input wire [255:0] image,
  output reg xfer_start = 0,
  output reg word_strobe = 0,
  output reg [31:0] word_data = 0
);
  initial forever begin
    @(posedge core_clk);
    if (go) begin // full image, ones for lamps that stay lit
      #1 xfer_start = 1;
      @(posedge core_clk) #1 xfer_start = 0;
      for (int k = 0; k < 8; k++) begin
        word_strobe = 1;
        word_data = image[32*k+:32];
        @(posedge core_clk) #1;
      end
      word_strobe = 0;
      word_data = ~word_data; // no stale word left
    end
  end
endmodule // host_image

// ---- sim/tb_warning_light_driver.sv ----
// bench for the warning light block
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; $display("wrong value %s %h %h", n, e, g); end end
module tb_warning_light_driver;
  logic core_clk = 0, rst_n = 0, go = 0, xfer_start, word_strobe, xfer_busy, xfer_done;
  logic [31:0] word_data;
  logic [7:0] silence_btn = 0, alarm_out;
  logic [255:0] image, lamp_out;
  int err_count = 0, total_checks = 0, cyc = 0;
  initial forever #10 core_clk = ~core_clk;
  host_image host_image_i (.*);
  warning_light_driver warning_light_driver_i (.*);
  task end_of_test;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one whole transfer, bounded wait for done
  task send(input logic [255:0] v);
    image = v;
    go = 1;
    @(posedge core_clk) #1 go = 0;
    for (int i = 0; i < 20 && xfer_done !== 1; i++) @(posedge core_clk) #1;
    `CHK("done", 1'b1, xfer_done)
  endtask
  task t_load;
    send(256'h8888888877777777666666665555555544444444333333332222222211111111);
    `CHK("lamps", image, lamp_out)
    `CHK("alarms", 8'h55, alarm_out)
  endtask
  task t_alarm;
    silence_btn = 8'h01;
    repeat (4) @(posedge core_clk) #1;
    silence_btn = 0;
    `CHK("alarms", 8'h54, alarm_out)
    send(256'h1);
    `CHK("lamps", 256'h1, lamp_out)
    `CHK("alarms", 8'h00, alarm_out)
    send(256'h0);
    send(256'h1);
    `CHK("alarms", 8'h01, alarm_out)
  endtask
  initial begin
    repeat (2) @(posedge core_clk) #1;
    rst_n = 1;
    t_load;
    t_alarm;
    end_of_test;
  end
  always @(posedge core_clk) if (++cyc > 500) begin err_count++; end_of_test; end
endmodule // tb_warning_light_driver

// ---- sim/wl_sva.sv ----
// port checks for the warning light block
`timescale 1ns/1ps
module wl_sva (input wire core_clk, rst_n, xfer_start, word_strobe, xfer_busy, xfer_done,
  input wire [31:0] word_data, input wire [255:0] lamp_out, input wire [7:0] silence_btn, alarm_out);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire l = lamp_out[0], a = alarm_out[0], b = silence_btn[0];
  open_busy_a: assert property (xfer_start && !xfer_busy |=> xfer_busy) else $error("no busy");
  first_word_a: assert property (xfer_start && !xfer_busy ##1 word_strobe |=> lamp_out[31:0] == $past(word_data))
    else $error("word 0 misplaced");
  done_cause_a: assert property (xfer_done |-> !xfer_busy && $past(word_strobe)) else $error("bad done");
  lamp_hold_a: assert property (!word_strobe |=> $stable(lamp_out)) else $error("lamp moved");
  alarm_bit_a: assert property (a |-> l) else $error("alarm without bit");
  silence_a: assert property ((l && b) [*3] |=> !a) else $error("not silenced");
  stay_off_a: assert property (l && !a ##1 l |-> !a) else $error("alarm rearmed");
  rearm_a: assert property ((!l && !b) [*4] ##1 l |-> a) else $error("no rearm");
endmodule // wl_sva
bind warning_light_driver wl_sva wl_sva_i (.*);
